// ==== shared/nhp_pkg.sv ====
// Package for the numeric value exchange port.
// Assumes a 40 MHz pclk; shared by the port and its sync stage.
package nhp_pkg;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned WIN_MS       = 15;
  // 15 ms minimum window as pclk cycles
  localparam int unsigned WIN_CYC      = (CLK_HZ / 1000) * WIN_MS;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned NUM_STROBES  = 6;
  // Strobe bit positions in the synchronised vector
  localparam int unsigned SB_PSEL      = 0;
  localparam int unsigned SB_OSEL      = 1;
  localparam int unsigned SB_PRGO      = 2;
  localparam int unsigned SB_LINO      = 3;
  localparam int unsigned SB_OVRO      = 4;
  localparam int unsigned SB_ERRO      = 5;
  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_PROG      = 8'h04;
  localparam logic [7:0] OFF_OVRD      = 8'h08;
  localparam logic [7:0] OFF_LINE      = 8'h0C;
  localparam logic [7:0] OFF_ERR       = 8'h10;
  localparam logic [7:0] OFF_STAT      = 8'h14;
  localparam logic [7:0] OFF_WIDTH     = 8'h18;
  // Reset values
  localparam logic [4:0] RST_START_BIT = 5'h00;
  localparam logic [4:0] RST_END_BIT   = 5'h0F;
  localparam logic [15:0] RST_OVRD     = 16'h0064;
  // Output source selector
  typedef enum logic [2:0] {
    NHP_SRC_NONE = 3'b000,
    NHP_SRC_PROG = 3'b001,
    NHP_SRC_LINE = 3'b010,
    NHP_SRC_OVRD = 3'b011,
    NHP_SRC_ERR  = 3'b100
  } nhp_src_e;
endpackage

// ==== rtl/nhp_sync.sv ====
// Three-flop synchroniser with agreed rising-edge detect per strobe.
// Assumes inputs come from outside the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module nhp_sync
  import nhp_pkg::*;
#(
  parameter int unsigned N = NUM_STROBES
)(
  input  wire logic         pclk,    // Clock
  input  wire logic         presetn, // Async reset, low
  input  wire logic [N-1:0] async_in, // Raw pins
  output logic      [N-1:0] level,   // Agreed level
  output logic      [N-1:0] rise     // One-cycle rising pulse
);
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_bit
      logic s1_r, s2_r, s3_r, lvl_r;
      // Three flops; level changes when stage 2 and 3 agree
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          s1_r  <= 1'b0;
          s2_r  <= 1'b0;
          s3_r  <= 1'b0;
          lvl_r <= 1'b0;
        end
        else
        begin
          s1_r <= async_in[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
            lvl_r <= s3_r;
        end
      end
      assign level[g] = lvl_r;
      assign rise[g]  = (s2_r == s3_r) && s3_r && !lvl_r;
    end
  endgenerate
endmodule // nhp_sync
`default_nettype wire

// ==== rtl/nhp_port.sv ====
// Numeric value exchange port: host strobes, numeric word in/out, APB.
// Assumes an APB master on pclk; host pins are asynchronous.
//
// Operation
// - Program select captures unsigned program number when start-select option off
// - Start-select option captures number at start
// - Override select captures new override value
// - Word width set by start/end bits
// - Latest output request selects output source
// - Program request outputs slot-1 program number
// - Line request outputs slot-1 line number
// - Override request outputs panel override
// - Error request outputs error number
// - Per-request in-progress flag while word valid
`timescale 1ns/1ps
`default_nettype none
module nhp_port
  import nhp_pkg::*;
#(
  parameter int unsigned W = WORD_W
)(
  input  wire logic         pclk,           // Clock 40 MHz
  input  wire logic         presetn,        // Async reset, low
  input  wire logic         psel,           // APB select
  input  wire logic         penable,        // APB enable
  input  wire logic         pwrite,         // APB direction
  input  wire logic [7:0]   paddr,          // APB byte address
  input  wire logic [31:0]  pwdata,         // APB write data
  output logic      [31:0]  prdata,         // APB read data
  output logic              pready,         // APB ready
  output logic              pslverr,        // APB error
  input  wire logic [W-1:0] numeric_word_in, // Host numeric input
  input  wire logic         program_select_strobe,  // Program select
  input  wire logic         override_select_strobe, // Override select
  input  wire logic         start_strobe,   // Start signal
  input  wire logic         program_number_request, // Program out req
  input  wire logic         line_number_request,    // Line out req
  input  wire logic         override_value_request, // Override out req
  input  wire logic         error_number_request,   // Error out req
  output logic [W-1:0]      numeric_word_out, // Numeric output
  output logic              prog_out_busy,  // Program output active
  output logic              line_out_busy,  // Line output active
  output logic              ovrd_out_busy,  // Override output active
  output logic              err_out_busy,   // Error output active
  output logic              program_start   // Start pulse to sequencer
);
  logic [NUM_STROBES-1:0] raw_s, lvl_s, rise_s;
  logic [W-1:0]  in_s1_r, in_s2_r, in_s3_r, in_stable_r;
  logic          pst_opt_r;
  logic [4:0]    start_bit_r, end_bit_r;
  logic [W-1:0]  prog_r, ovrd_r, line_r, err_r;
  logic [W-1:0]  width_mask, in_val, out_val;
  nhp_src_e      src_r, src_nxt;
  logic          wr_en;

  assign raw_s = {error_number_request, override_value_request,
                  line_number_request, program_number_request,
                  override_select_strobe, program_select_strobe};

  // Strobe synchronisation and edge detect
  nhp_sync #(.N(NUM_STROBES)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (raw_s),
    .level    (lvl_s),
    .rise     (rise_s)
  );

  // Start strobe through its own three flops
  logic st1_r, st2_r, st3_r, st_lvl_r, st_rise;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st1_r    <= 1'b0;
      st2_r    <= 1'b0;
      st3_r    <= 1'b0;
      st_lvl_r <= 1'b0;
    end
    else
    begin
      st1_r <= start_strobe;
      st2_r <= st1_r;
      st3_r <= st2_r;
      if (st2_r == st3_r)
        st_lvl_r <= st3_r;
    end
  end
  assign st_rise = (st2_r == st3_r) && st3_r && !st_lvl_r;
  assign program_start = st_rise;

  // Numeric input word taken as a level, agreed per bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_s1_r     <= '0;
      in_s2_r     <= '0;
      in_s3_r     <= '0;
      in_stable_r <= '0;
    end
    else
    begin
      in_s1_r <= numeric_word_in;
      in_s2_r <= in_s1_r;
      in_s3_r <= in_s2_r;
      for (int i = 0; i < W; i++)
        if (in_s2_r[i] == in_s3_r[i])
          in_stable_r[i] <= in_s3_r[i];
    end
  end

  // Field window from start and end bit positions
  always_comb
  begin
    width_mask = '0;
    for (int i = 0; i < W; i++)
      if (i <= int'(end_bit_r) - int'(start_bit_r))
        width_mask[i] = 1'b1;
  end
  assign in_val = (in_stable_r >> start_bit_r) & width_mask;

  // APB decode; zero wait states
  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr > OFF_WIDTH
                   || paddr[1:0] != 2'b00);

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pst_opt_r   <= 1'b0;
      start_bit_r <= RST_START_BIT;
      end_bit_r   <= RST_END_BIT;
    end
    else if (wr_en && paddr == OFF_CTRL)
      pst_opt_r <= pwdata[0];
    else if (wr_en && paddr == OFF_WIDTH)
    begin
      start_bit_r <= pwdata[4:0];
      end_bit_r   <= pwdata[12:8];
    end
  end

  // Program number capture, select strobe or start option
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prog_r <= '0;
    else if (rise_s[SB_PSEL] && !pst_opt_r)
      prog_r <= in_val;
    else if (st_rise && pst_opt_r)
      prog_r <= in_val;
    else if (wr_en && paddr == OFF_PROG)
      prog_r <= pwdata[W-1:0];
  end

  // Override capture, select strobe wins over software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovrd_r <= RST_OVRD[W-1:0];
    else if (rise_s[SB_OSEL])
      ovrd_r <= in_val;
    else if (wr_en && paddr == OFF_OVRD)
      ovrd_r <= pwdata[W-1:0];
  end

  // Line and error numbers supplied by the controller
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_r <= '0;
      err_r  <= '0;
    end
    else if (wr_en && paddr == OFF_LINE)
      line_r <= pwdata[W-1:0];
    else if (wr_en && paddr == OFF_ERR)
      err_r <= pwdata[W-1:0];
  end

  // Source selection: latest rising request takes over
  always_comb
  begin
    src_nxt = src_r;
    case (src_r)
      NHP_SRC_PROG: if (!lvl_s[SB_PRGO]) src_nxt = NHP_SRC_NONE;
      NHP_SRC_LINE: if (!lvl_s[SB_LINO]) src_nxt = NHP_SRC_NONE;
      NHP_SRC_OVRD: if (!lvl_s[SB_OVRO]) src_nxt = NHP_SRC_NONE;
      NHP_SRC_ERR:  if (!lvl_s[SB_ERRO]) src_nxt = NHP_SRC_NONE;
      NHP_SRC_NONE: src_nxt = NHP_SRC_NONE;
      default:      src_nxt = NHP_SRC_NONE;
    endcase
    if (rise_s[SB_PRGO])
      src_nxt = NHP_SRC_PROG;
    else if (rise_s[SB_LINO])
      src_nxt = NHP_SRC_LINE;
    else if (rise_s[SB_OVRO])
      src_nxt = NHP_SRC_OVRD;
    else if (rise_s[SB_ERRO])
      src_nxt = NHP_SRC_ERR;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      src_r <= NHP_SRC_NONE;
    else
      src_r <= src_nxt;
  end

  // Output value by source, placed at the configured field
  always_comb
  begin
    case (src_r)
      NHP_SRC_PROG: out_val = prog_r;
      NHP_SRC_LINE: out_val = line_r;
      NHP_SRC_OVRD: out_val = ovrd_r;
      NHP_SRC_ERR:  out_val = err_r;
      default:      out_val = '0;
    endcase
  end

  // Registered numeric word and in-progress flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      numeric_word_out <= '0;
      prog_out_busy    <= 1'b0;
      line_out_busy    <= 1'b0;
      ovrd_out_busy    <= 1'b0;
      err_out_busy     <= 1'b0;
    end
    else
    begin
      numeric_word_out <= (out_val & width_mask) << start_bit_r;
      prog_out_busy    <= (src_r == NHP_SRC_PROG);
      line_out_busy    <= (src_r == NHP_SRC_LINE);
      ovrd_out_busy    <= (src_r == NHP_SRC_OVRD);
      err_out_busy     <= (src_r == NHP_SRC_ERR);
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        OFF_CTRL:  prdata <= {31'h0, pst_opt_r};
        OFF_PROG:  prdata <= 32'(prog_r);
        OFF_OVRD:  prdata <= 32'(ovrd_r);
        OFF_LINE:  prdata <= 32'(line_r);
        OFF_ERR:   prdata <= 32'(err_r);
        OFF_STAT:  prdata <= {25'h0, lvl_s[5:2], src_r};
        OFF_WIDTH: prdata <= {19'h0, end_bit_r, 3'h0, start_bit_r};
        default:   prdata <= 32'h00000000;
      endcase
    end
  end

  // Checks
  chk_prog_capture: assert property (
    @(posedge pclk) disable iff (!presetn)
    rise_s[SB_PSEL] && !pst_opt_r |=> prog_r == $past(in_val))
    else $error("program number not captured");
  chk_start_capture: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_rise && pst_opt_r |=> prog_r == $past(in_val))
    else $error("program number not captured at start");
  chk_ovrd_capture: assert property (
    @(posedge pclk) disable iff (!presetn)
    rise_s[SB_OSEL] |=> ovrd_r == $past(in_val))
    else $error("override not captured");
  chk_prog_out_busy: assert property (
    @(posedge pclk) disable iff (!presetn)
    rise_s[SB_PRGO] |=> ##1 prog_out_busy && !line_out_busy)
    else $error("program busy flag missing");
  chk_line_value: assert property (
    @(posedge pclk) disable iff (!presetn)
    rise_s[SB_LINO] && !rise_s[SB_PRGO] && start_bit_r == 5'h00
    && end_bit_r == RST_END_BIT
    |=> ##1 numeric_word_out == $past(line_r))
    else $error("line number not output");
  chk_err_out: assert property (
    @(posedge pclk) disable iff (!presetn)
    rise_s[SB_ERRO] && rise_s[4:2] == 3'h0 |=> ##1 err_out_busy)
    else $error("error output flag missing");
  chk_release_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    src_r == NHP_SRC_OVRD && !lvl_s[SB_OVRO] && rise_s[5:2] == 4'h0
    |=> ##1 !ovrd_out_busy)
    else $error("override flag not released");
  chk_one_busy: assert property (
    @(posedge pclk) disable iff (!presetn)
    $onehot0({prog_out_busy, line_out_busy, ovrd_out_busy,
              err_out_busy}))
    else $error("more than one busy flag");
  cov_prog_req: cover property (@(posedge pclk) disable iff (!presetn)
    rise_s[SB_PRGO] ##2 prog_out_busy);
  cov_takeover: cover property (@(posedge pclk) disable iff (!presetn)
    src_r == NHP_SRC_LINE ##1 src_r == NHP_SRC_ERR);
  cov_ovrd_set: cover property (@(posedge pclk) disable iff (!presetn)
    rise_s[SB_OSEL]);
endmodule // nhp_port
`default_nettype wire

// ==== verif/nhp_host.sv ====
// Host controller model: numeric input word, setting strobes, requests.
// Assumes pins are sampled asynchronously by the port; HOLD scales 15 ms.
`timescale 1ns/1ps
`default_nettype none
module nhp_host
  import nhp_pkg::*;
#(
  parameter int unsigned HOLD = 12
)(
  input  wire logic              pclk,     // Clock
  output logic      [WORD_W-1:0] word,     // Numeric input word
  output logic                   prog_sel, // Program select strobe
  output logic                   ovrd_sel, // Override select strobe
  output logic                   start,    // Start strobe
  output logic      [3:0]        req       // Requests prog,line,ovrd,err
);
  // Idle pin levels
  initial
  begin
    word     = '0;
    prog_sel = 1'b0;
    ovrd_sel = 1'b0;
    start    = 1'b0;
    req      = '0;
  end
  // Word settles, strobe held, then word moves away
  task automatic setting(input int kind, input logic [WORD_W-1:0] v);
    word <= v;
    repeat (HOLD) @(posedge pclk);
    if (kind == 0)
      prog_sel <= 1'b1;
    else if (kind == 1)
      ovrd_sel <= 1'b1;
    else
      start <= 1'b1;
    repeat (HOLD) @(posedge pclk);
    prog_sel <= 1'b0;
    ovrd_sel <= 1'b0;
    start    <= 1'b0;
    word     <= ~v;
    @(posedge pclk);
  endtask
  // Request level change, then wait before the word is read
  task automatic request(input int idx, input logic on);
    req[idx] <= on;
    repeat (HOLD) @(posedge pclk);
  endtask
endmodule // nhp_host
`default_nettype wire

// ==== verif/nhp_port_tb.sv ====
// Self-checking bench for the numeric value exchange port.
// Assumes nhp_host as the far side and an APB master in this module.
`timescale 1ns/1ps
`default_nettype none
module nhp_port_tb;
  import nhp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] wi, wo;
  logic        psl, osl, sst, pb, lb, ob, eb, program_start_select_option;
  logic [3:0]  req;
  int          failures, compares, starts;

  nhp_port nhp_port_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .numeric_word_in(wi), .program_select_strobe(psl),
    .override_select_strobe(osl), .start_strobe(sst),
    .program_number_request(req[0]), .line_number_request(req[1]),
    .override_value_request(req[2]), .error_number_request(req[3]),
    .numeric_word_out(wo), .prog_out_busy(pb), .line_out_busy(lb),
    .ovrd_out_busy(ob), .err_out_busy(eb), .program_start(program_start_select_option));
  nhp_host nhp_host_i (.pclk(pclk), .word(wi), .prog_sel(psl),
    .ovrd_sel(osl), .start(sst), .req(req));

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Start pulse counter
  always @(posedge pclk)
    if (program_start_select_option === 1'b1)
      starts <= starts + 1;
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic look(input logic [15:0] w, input logic [3:0] f);
    chk("numeric_word_out", {16'h0000, w}, {16'h0000, wo});
    chk("busy_flags", {28'h0, f}, {28'h0, eb, ob, lb, pb});
  endtask
  // Setup, access held until pready, then release and idle
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h00000000, q, e);
    chk("prdata", x, q);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
    chk("pready", 32'h00000001, {31'h0, pready});
  endtask
  task automatic t_reset;
    look(16'h0000, 4'h0);
    rd(OFF_OVRD, {16'h0000, RST_OVRD}, 1'b0);
    rd(OFF_WIDTH, {19'h0, RST_END_BIT, 3'h0, RST_START_BIT}, 1'b0);
    rd(8'h1C, 32'h00000000, 1'b1);
  endtask
  task automatic t_prog;
    nhp_host_i.setting(0, 16'h0123);
    nhp_host_i.request(0, 1'b1);
    look(16'h0123, 4'h1);
    nhp_host_i.request(0, 1'b0);
    look(16'h0000, 4'h0);
  endtask
  task automatic t_takeover;
    nhp_host_i.setting(1, 16'h0042);
    wr(OFF_LINE, 32'h00000007);
    wr(OFF_ERR, 32'h00000055);
    rd(OFF_OVRD, 32'h00000042, 1'b0);
    nhp_host_i.request(2, 1'b1);
    look(16'h0042, 4'h4);
    nhp_host_i.request(1, 1'b1);
    look(16'h0007, 4'h2);
    rd(OFF_STAT, 32'h00000032, 1'b0);
    nhp_host_i.request(3, 1'b1);
    look(16'h0055, 4'h8);
    nhp_host_i.request(2, 1'b0);
    nhp_host_i.request(1, 1'b0);
    look(16'h0055, 4'h8);
    nhp_host_i.request(3, 1'b0);
    look(16'h0000, 4'h0);
  endtask
  task automatic t_start;
    wr(OFF_CTRL, 32'h00000001);
    nhp_host_i.setting(0, 16'h0099);
    nhp_host_i.request(0, 1'b1);
    look(16'h0123, 4'h1);
    nhp_host_i.request(0, 1'b0);
    nhp_host_i.setting(2, 16'h0033);
    chk("program_start", 32'h00000001, starts);
    nhp_host_i.request(0, 1'b1);
    look(16'h0033, 4'h1);
    nhp_host_i.request(0, 1'b0);
    wr(OFF_CTRL, 32'h00000000);
  endtask
  task automatic t_width;
    wr(OFF_WIDTH, 32'h00000704);
    nhp_host_i.setting(1, 16'h0AB0);
    rd(OFF_OVRD, 32'h0000000B, 1'b0);
    nhp_host_i.request(2, 1'b1);
    look(16'h00B0, 4'h4);
    nhp_host_i.request(2, 1'b0);
  endtask
  task automatic summarize;
    if (failures == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #125000;
    failures++;
    summarize;
  end
  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
    starts  = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_prog;
    t_takeover;
    t_start;
    t_width;
    summarize;
  end
endmodule // nhp_port_tb
`default_nettype wire
